/* src/table_ops_pkg.sv */
// Shared constants and types for the table operation engine
package table_ops_pkg;
  localparam int unsigned ADDR_W      = 16;
  localparam int unsigned DATA_W      = 16;
  localparam int unsigned LEN_W       = 8;
  localparam int unsigned OP_W        = 3;
  localparam logic [15:0] MAX_LEN     = 16'h00ff;
  // Shift operand is octal: three bits per digit, four digits
  localparam int unsigned OCT_DIGITS  = 4;
  localparam int unsigned SHAMT_W     = 13;
  localparam logic [3:0]  WORD_BITS_LOG2 = 4'h4;

  typedef enum logic [2:0] {
    table_shift_left  = 3'h0,
    table_shift_right = 3'h1,
    masked_and_copy   = 3'h2,
    masked_or_copy    = 3'h3,
    masked_xor_copy   = 3'h4,
    block_search      = 3'h5,
    table_swap        = 3'h6,
    op_none           = 3'h7
  } op_type;
endpackage

/* src/word_mem_if.sv */
// Word memory request/answer bundle between engine and its memory port
`timescale 1ns/1ps
interface word_mem_if;
  logic        req;
  logic        we;
  logic [15:0] addr;
  logic [15:0] wdata;
  logic        gnt;
  logic        rvalid;
  logic [15:0] rdata;
  modport engine (output req, output we, output addr, output wdata, input gnt, input rvalid, input rdata);
  modport port   (input req, input we, input addr, input wdata, output gnt, output rvalid, output rdata);
endinterface

/* src/word_mem_port.sv */
// Registers the engine's memory request onto the device pins and returns read data
`timescale 1ns/1ps
module word_mem_port (
  input  wire logic        clk,
  input  wire logic        resetn,
  word_mem_if.port         bus,
  output logic             mem_req,
  output logic             mem_we,
  output logic [15:0]      mem_addr,
  output logic [15:0]      mem_wdata,
  input  wire logic        mem_ack,
  input  wire logic [15:0] mem_rdata
);
  logic busy_reg;

  // One access outstanding at a time; a grant is given only when idle
  assign bus.gnt    = bus.req && !busy_reg;
  assign bus.rvalid = busy_reg && mem_ack;
  assign bus.rdata  = mem_rdata;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busy_reg  <= 1'b0;
      mem_req   <= 1'b0;
      mem_we    <= 1'b0;
      mem_addr  <= 16'h0000;
      mem_wdata <= 16'h0000;
    end else if (bus.gnt) begin
      busy_reg  <= 1'b1;
      mem_req   <= 1'b1;
      mem_we    <= bus.we;
      mem_addr  <= bus.addr;
      mem_wdata <= bus.wdata;
    end else if (busy_reg && mem_ack) begin
      busy_reg <= 1'b0;
      mem_req  <= 1'b0;
    end
  end
endmodule

/* src/table_block_ops_engine.sv */
// Table operation engine: bit shifts, masked copies, block search and swap over word memory
`timescale 1ns/1ps
module table_block_ops_engine #(
  parameter int unsigned ADDR_W = table_ops_pkg::ADDR_W
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        start,
  input  wire logic [2:0]  op,
  input  wire logic [15:0] acc_in,
  input  wire logic [15:0] stack1_in,
  input  wire logic [15:0] stack2_in,
  input  wire logic [15:0] stack3_in,
  input  wire logic [15:0] operand,
  input  wire logic        scan_end,
  output logic             busy,
  output logic             done,
  output logic [15:0]      acc_out,
  output logic             acc_out_valid,
  output logic             overflow_or_search_fail_flag,
  output logic             lost_one_bit_flag,
  output logic             mem_req,
  output logic             mem_we,
  output logic [15:0]      mem_addr,
  output logic [15:0]      mem_wdata,
  input  wire logic        mem_ack,
  input  wire logic [15:0] mem_rdata
);
  typedef enum logic [6:0] {
    st_idle  = 7'b0000001,
    st_rd_a  = 7'b0000010,
    st_rd_b  = 7'b0000100,
    st_wr_a  = 7'b0001000,
    st_wr_b  = 7'b0010000,
    st_next  = 7'b0100000,
    st_done  = 7'b1000000
  } state_type;

  word_mem_if mif ();

  state_type   state_reg;
  logic [2:0]  op_reg;
  logic [15:0] len_reg;      // Table length in words
  logic [15:0] a_base_reg;   // Source / first table / search region start
  logic [15:0] b_base_reg;   // Destination / second table / search block
  logic [15:0] pat_reg;
  logic [15:0] end_reg;      // Search region end
  logic [15:0] blk_words_reg;
  logic [15:0] idx_reg;      // Word index within table, or within block for search
  logic [15:0] tab_reg;      // Search: current candidate start address
  logic [15:0] a_word_reg;
  logic [15:0] b_word_reg;
  logic [3:0]  bit_sh_reg;
  logic [15:0] word_sh_reg;
  logic        mismatch_reg;
  logic        issued_reg;
  logic        lost_ok_reg;  // Distance within the table, so one real bit falls off the end

  // Octal digits to binary bit count
  logic [15:0] shamt_bin;
  always_comb begin
    shamt_bin = 16'h0000;
    for (int i = table_ops_pkg::OCT_DIGITS - 1; i >= 0; i--) begin
      shamt_bin = 16'((shamt_bin << 3) + 16'(operand[i*4 +: 3]));
    end
  end

  // Distance split as 16*k + (b+1), b in 0..15, so word k from the start (left) or from the end (right) holds the last dropped bit
  logic [15:0] shamt_m1;
  assign shamt_m1 = shamt_bin - 16'h0001;

  logic [23:0] total_bits;
  assign total_bits = {stack1_in[7:0], 16'h0000} >> (16 - table_ops_pkg::WORD_BITS_LOG2);

  // Nothing to read or write: empty table, zero distance or no operation
  logic start_skip;
  always_comb begin
    case (op)
      table_ops_pkg::masked_and_copy, table_ops_pkg::masked_or_copy, table_ops_pkg::masked_xor_copy:
        start_skip = (stack2_in[7:0] == 8'h00);
      table_ops_pkg::table_shift_left, table_ops_pkg::table_shift_right:
        start_skip = (stack1_in[7:0] == 8'h00) || (shamt_bin == 16'h0000);
      table_ops_pkg::block_search: start_skip = 1'b0;
      table_ops_pkg::table_swap:   start_skip = (stack1_in[7:0] == 8'h00);
      default:                     start_skip = 1'b1;
    endcase
  end

  // Shift reads words in an order that never reads a word already rewritten:
  // left walks up from word 0, right walks down from the last word.
  logic [15:0] word_addr;
  assign word_addr = (op_reg == table_ops_pkg::table_shift_right) ? (len_reg - 16'h0001 - idx_reg) : idx_reg;

  // Source index for shift: word i draws from words i+k and i+k+1 (left) or i-k-1, i-k (right)
  logic [16:0] src_hi;
  logic [16:0] src_lo;
  logic        hi_ok;
  logic        lo_ok;
  always_comb begin
    if (op_reg == table_ops_pkg::table_shift_left) begin
      src_hi = {1'b0, word_addr} + {1'b0, word_sh_reg};
      src_lo = src_hi + 17'h00001;
    end else begin
      src_lo = {1'b0, word_addr} - {1'b0, word_sh_reg};
      src_hi = src_lo - 17'h00001;
    end
    hi_ok = !src_hi[16] && (src_hi[15:0] < len_reg);
    lo_ok = !src_lo[16] && (src_lo[15:0] < len_reg);
  end

  // word 0 at lowest address is the left (most significant) end of the chain
  logic [31:0] pair;
  logic [15:0] shifted_word;
  always_comb begin
    pair = {(hi_ok ? a_word_reg : 16'h0000), (lo_ok ? b_word_reg : 16'h0000)};
    if (op_reg == table_ops_pkg::table_shift_left)
      shifted_word = 16'(pair >> (4'hf - bit_sh_reg));
    else
      shifted_word = 16'(pair >> ({1'b0, bit_sh_reg} + 5'h01));
  end

  // Last dropped bit: left finds it in the first read word, right in the second read word
  logic lost_bit_l;
  logic lost_bit_r;
  assign lost_bit_l = mif.rdata[4'hf - bit_sh_reg];
  assign lost_bit_r = mif.rdata[bit_sh_reg];

  logic [15:0] logic_word;
  always_comb begin
    case (op_reg)
      table_ops_pkg::masked_and_copy: logic_word = a_word_reg & pat_reg;
      table_ops_pkg::masked_or_copy:  logic_word = a_word_reg | pat_reg;
      default:                        logic_word = a_word_reg ^ pat_reg;
    endcase
  end

  logic is_shift;
  logic is_copy;
  logic is_search;
  assign is_shift  = (op_reg == table_ops_pkg::table_shift_left) || (op_reg == table_ops_pkg::table_shift_right);
  assign is_copy   = (op_reg == table_ops_pkg::masked_and_copy) || (op_reg == table_ops_pkg::masked_or_copy)
                     || (op_reg == table_ops_pkg::masked_xor_copy);
  assign is_search = (op_reg == table_ops_pkg::block_search);

  always_comb begin
    mif.req   = 1'b0;
    mif.we    = 1'b0;
    mif.addr  = 16'h0000;
    mif.wdata = 16'h0000;
    if (!issued_reg) begin
      case (state_reg)
        st_rd_a: begin
          mif.req = 1'b1;
          if (is_shift) mif.addr = a_base_reg + src_hi[15:0];
          else if (is_search) mif.addr = tab_reg + idx_reg;
          else mif.addr = a_base_reg + idx_reg;
        end
        st_rd_b: begin
          mif.req  = 1'b1;
          mif.addr = is_shift ? (a_base_reg + src_lo[15:0]) : (b_base_reg + idx_reg);
        end
        st_wr_a: begin
          mif.req   = 1'b1;
          mif.we    = 1'b1;
          mif.addr  = is_shift ? (a_base_reg + word_addr) : (b_base_reg + idx_reg);
          mif.wdata = is_shift ? shifted_word : (is_copy ? logic_word : a_word_reg);
        end
        st_wr_b: begin
          mif.req   = 1'b1;
          mif.we    = 1'b1;
          mif.addr  = a_base_reg + idx_reg;
          mif.wdata = b_word_reg;
        end
        default: mif.req = 1'b0;
      endcase
    end
  end

  word_mem_port u_port (
    .clk       (clk),
    .resetn    (resetn),
    .bus       (mif.port),
    .mem_req   (mem_req),
    .mem_we    (mem_we),
    .mem_addr  (mem_addr),
    .mem_wdata (mem_wdata),
    .mem_ack   (mem_ack),
    .mem_rdata (mem_rdata)
  );

  logic last_word;
  assign last_word = (idx_reg + 16'h0001) >= (is_search ? blk_words_reg : len_reg);

  // Sequencer
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= st_idle;
      issued_reg <= 1'b0;
      op_reg <= table_ops_pkg::op_none;
      len_reg <= 16'h0000; a_base_reg <= 16'h0000; b_base_reg <= 16'h0000;
      pat_reg <= 16'h0000; end_reg <= 16'h0000; blk_words_reg <= 16'h0000;
      idx_reg <= 16'h0000; tab_reg <= 16'h0000; a_word_reg <= 16'h0000; b_word_reg <= 16'h0000;
      bit_sh_reg <= 4'h0; word_sh_reg <= 16'h0000; mismatch_reg <= 1'b0;
      lost_ok_reg <= 1'b0;
    end else begin
      if (mif.gnt) issued_reg <= 1'b1;
      if (mif.rvalid) issued_reg <= 1'b0;
      case (state_reg)
        st_idle: if (start) begin
          op_reg  <= op;
          idx_reg <= 16'h0000;
          lost_ok_reg <= (shamt_bin != 16'h0000) && ({8'h00, shamt_bin} <= total_bits);
          mismatch_reg <= 1'b0;
          len_reg <= {8'h00, stack1_in[7:0]};
          case (op)
            table_ops_pkg::masked_and_copy, table_ops_pkg::masked_or_copy, table_ops_pkg::masked_xor_copy: begin
              a_base_reg <= stack1_in; len_reg <= {8'h00, stack2_in[7:0]}; pat_reg <= acc_in;
              b_base_reg <= operand;
            end
            table_ops_pkg::block_search: begin
              blk_words_reg <= 16'({8'h00, stack3_in[7:0]} + 16'h0001) >> 1;
              len_reg <= {8'h00, stack2_in[7:0]};
              end_reg <= stack1_in; a_base_reg <= acc_in; tab_reg <= acc_in; b_base_reg <= operand;
            end
            default: begin
              a_base_reg <= acc_in; b_base_reg <= operand;
              bit_sh_reg <= shamt_m1[3:0];
              word_sh_reg <= {4'h0, shamt_m1[15:4]};
            end
          endcase
          state_reg <= start_skip ? st_done : st_rd_a;
        end
        st_rd_a: if (mif.rvalid) begin
          a_word_reg <= mif.rdata;
          state_reg  <= (is_shift || op_reg == table_ops_pkg::table_swap || is_search) ? st_rd_b : st_wr_a;
        end
        st_rd_b: if (mif.rvalid) begin
          b_word_reg <= mif.rdata;
          state_reg  <= is_search ? st_next : st_wr_a;
          if (is_search && mif.rdata != a_word_reg) mismatch_reg <= 1'b1;
        end
        st_wr_a: if (mif.rvalid)
          state_reg <= (op_reg == table_ops_pkg::table_swap) ? st_wr_b : st_next;
        st_wr_b: if (mif.rvalid) state_reg <= st_next;
        st_next: begin
          if (is_search) begin
            if (last_word && !mismatch_reg) state_reg <= st_done;
            else if (last_word || mismatch_reg) begin
              idx_reg <= 16'h0000; mismatch_reg <= 1'b0;
              tab_reg <= tab_reg + len_reg;
              state_reg <= (tab_reg + len_reg > end_reg || len_reg == 16'h0000) ? st_done : st_rd_a;
            end else begin
              idx_reg <= idx_reg + 16'h0001; state_reg <= st_rd_a;
            end
          end else if (last_word) state_reg <= st_done;
          else begin
            idx_reg <= idx_reg + 16'h0001; state_reg <= st_rd_a;
          end
        end
        st_done: state_reg <= st_idle;
        default: state_reg <= st_idle;
      endcase
    end
  end

  assign busy = (state_reg != st_idle);
  logic search_hit;
  assign search_hit = (state_reg == st_next) && is_search && last_word && !mismatch_reg;

  // Completion, accumulator answer and flags
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      done <= 1'b0; acc_out <= 16'h0000; acc_out_valid <= 1'b0;
      overflow_or_search_fail_flag <= 1'b0; lost_one_bit_flag <= 1'b0;
    end else begin
      done <= (state_reg == st_done);
      acc_out_valid <= 1'b0;
      if (scan_end) begin
        overflow_or_search_fail_flag <= 1'b0;
        lost_one_bit_flag <= 1'b0;
      end
      if (state_reg == st_idle && start) begin
        if (op == table_ops_pkg::table_shift_left || op == table_ops_pkg::table_shift_right) begin
          overflow_or_search_fail_flag <= ({8'h00, shamt_bin} > total_bits);
          lost_one_bit_flag <= 1'b0;
        end else if (op == table_ops_pkg::block_search)
          overflow_or_search_fail_flag <= 1'b0;
      end
      // Taken from the original word before any write of this shift can touch it
      if (lost_ok_reg && mif.rvalid && idx_reg == 16'h0000) begin
        if (state_reg == st_rd_a && op_reg == table_ops_pkg::table_shift_left)
          lost_one_bit_flag <= lost_bit_l;
        else if (state_reg == st_rd_b && op_reg == table_ops_pkg::table_shift_right)
          lost_one_bit_flag <= lost_bit_r;
      end
      if (search_hit) begin
        acc_out <= tab_reg;
        acc_out_valid <= 1'b1;
      end
      if (state_reg == st_next && is_search && (last_word || mismatch_reg) && !search_hit
          && (tab_reg + len_reg > end_reg || len_reg == 16'h0000))
        overflow_or_search_fail_flag <= 1'b1;
    end
  end

endmodule

/* dv/word_mem_model.sv */
// Word memory partner: answers one held request at a time, promptly or after random waits
`timescale 1ns/1ps
module word_mem_model (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        slow,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [15:0] mem_addr,
  input  wire logic [15:0] mem_wdata,
  output logic             mem_ack,
  output logic [15:0]      mem_rdata
);
  logic [15:0] words [0:255];
  int          wait_cnt;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mem_ack   <= 1'b0;
      mem_rdata <= 16'h0000;
      wait_cnt  <= 0;
    end else if (mem_ack) begin
      // The request seen at this edge is the one just answered
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
      wait_cnt  <= slow ? $urandom_range(3, 0) : 0;
    end else if (mem_req && wait_cnt > 0) begin
      wait_cnt  <= wait_cnt - 1;
      mem_rdata <= ~mem_rdata;
    end else if (mem_req) begin
      mem_ack <= 1'b1;
      if (mem_we) words[mem_addr[7:0]] <= mem_wdata;
      else mem_rdata <= words[mem_addr[7:0]];
    end else begin
      // Read data is only meaningful with the answer, so keep it moving otherwise
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule

/* dv/table_block_ops_engine_monitor.sv */
// Port-level assertions for the table operation engine
`timescale 1ns/1ps
module table_block_ops_engine_monitor #(
  parameter int unsigned ADDR_W = 16
) (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        start,
  input wire logic [2:0]  op,
  input wire logic [15:0] acc_in,
  input wire logic [15:0] stack1_in,
  input wire logic [15:0] stack2_in,
  input wire logic [15:0] stack3_in,
  input wire logic [15:0] operand,
  input wire logic        scan_end,
  input wire logic        busy,
  input wire logic        done,
  input wire logic [15:0] acc_out,
  input wire logic        acc_out_valid,
  input wire logic        overflow_or_search_fail_flag,
  input wire logic        lost_one_bit_flag,
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  input wire logic        mem_ack,
  input wire logic [15:0] mem_rdata
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // Shift with a non-empty table and a non-zero octal distance must touch memory
  sequence shift_taken;
    start && !busy && op <= 3'h1 && stack1_in[7:0] != 8'h00 && (operand & 16'h7777) != 16'h0000;
  endsequence
  sequence access_pending;
    mem_req && !mem_ack;
  endsequence
  a_shift_first_access: assert property (shift_taken |-> ##2 mem_req)
    else $error("shift did not reach memory two cycles after start");
  a_req_held_stable: assert property (access_pending |=> mem_req && $stable(mem_addr)
    && $stable(mem_we) && $stable(mem_wdata)) else $error("memory request changed before answer");
  a_req_only_busy: assert property (mem_req |-> busy)
    else $error("memory request outside an operation");
  a_done_no_access: assert property (done |-> !mem_req)
    else $error("done while a memory access is open");
  a_flags_hold: assert property (!busy && !$past(scan_end) |-> $stable(overflow_or_search_fail_flag)
    && $stable(lost_one_bit_flag)) else $error("flag changed while idle without scan end");
  a_scan_end_clears: assert property (scan_end && !busy && !done |=>
    !overflow_or_search_fail_flag && !lost_one_bit_flag) else $error("scan end did not clear flags");
  a_busy_from_start: assert property ($rose(busy) |-> $past(start))
    else $error("busy rose without start");
  a_done_one_pulse: assert property (done |=> !done)
    else $error("done longer than one cycle");
  a_valid_one_pulse: assert property (acc_out_valid |=> !acc_out_valid)
    else $error("result valid longer than one cycle");
endmodule
bind table_block_ops_engine table_block_ops_engine_monitor #(.ADDR_W(ADDR_W)) mon (.clk, .resetn, .start,
  .op, .acc_in, .stack1_in, .stack2_in, .stack3_in, .operand, .scan_end, .busy, .done, .acc_out, .acc_out_valid,
  .overflow_or_search_fail_flag, .lost_one_bit_flag, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack,
  .mem_rdata);

/* dv/table_block_ops_engine_tb_top.sv */
// Self-checking bench: engine against a word memory partner and a bit-queue reference
`timescale 1ns/1ps
`define CHK(nm, e, s) begin comparisons++; if ((s) !== (e)) begin fail_count++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, s); end end
module table_block_ops_engine_tb_top;
  logic        clk, resetn, start, scan_end, slow, busy, done, acc_out_valid;
  logic        overflow_or_search_fail_flag, lost_one_bit_flag, mem_req, mem_we, mem_ack;
  logic [2:0]  op;
  logic [15:0] acc_in, stack1_in, stack2_in, stack3_in, operand, acc_out, mem_addr, mem_wdata, mem_rdata;
  logic [15:0] exp_mem [0:255];
  logic [15:0] got_acc;
  bit          ovf_e, lost_e, lost_known;
  int          fail_count, comparisons;
  table_block_ops_engine DUT (.clk, .resetn, .start, .op, .acc_in, .stack1_in, .stack2_in, .stack3_in,
    .operand, .scan_end, .busy, .done, .acc_out, .acc_out_valid, .overflow_or_search_fail_flag,
    .lost_one_bit_flag, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata);
  word_mem_model mem (.clk, .resetn, .slow, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata);
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    // Somewhat over a thousand cycles are expected even with slow memory
    #(8 * 20000);
    fail_count++;
    results();
  end
  task automatic put_word(input int a, input logic [15:0] v);
    exp_mem[a] = v;
    mem.words[a] = v;
  endtask
  // Shift distance goes in as octal digits, one per nibble
  function automatic logic [15:0] octal_code(input int n);
    return {1'b0, 3'(n >> 9), 1'b0, 3'(n >> 6), 1'b0, 3'(n >> 3), 1'b0, 3'(n)};
  endfunction
  // A second start while busy (poke) must be ignored
  task automatic run_op(input logic [2:0] o, input logic [15:0] a, s1, s2, s3, d, input bit poke);
    int n;
    @(posedge clk);
    #1;
    {op, acc_in, stack1_in, stack2_in, stack3_in, operand} = {o, a, s1, s2, s3, d};
    start = 1'b1;
    got_acc = 16'hxxxx;
    for (n = 0; n < 20000 && !done; n++) begin
      @(posedge clk);
      #1;
      if (n == 0) `CHK("busy after start", 1'b1, busy)
      start = poke && n == 2;
      if (poke && n == 2) op = table_ops_pkg::table_swap;
      if (acc_out_valid) got_acc = acc_out;
    end
    `CHK("done seen", 1'b1, done)
  endtask
  task automatic check_mem;
    for (int i = 0; i < 256; i++) `CHK("memory word", exp_mem[i], mem.words[i])
  endtask
  task automatic check_flags;
    `CHK("overflow or search fail flag", ovf_e, overflow_or_search_fail_flag)
    if (lost_known) `CHK("lost one bit flag", lost_e, lost_one_bit_flag)
  endtask
  // Word 0 is the most significant end; a left shift moves bits toward word 0
  task automatic model_shift(input bit left, input int base, len, n);
    bit q[$];
    int i;
    for (i = 0; i < len * 16; i++) q.push_back(exp_mem[base + i / 16][15 - i % 16]);
    ovf_e = n > len * 16;
    lost_known = !ovf_e && n > 0;
    for (i = 0; i < n && i < len * 16; i++) begin
      if (left) begin lost_e = q.pop_front(); q.push_back(1'b0); end
      else begin lost_e = q.pop_back(); q.push_front(1'b0); end
    end
    for (i = 0; i < len * 16; i++) exp_mem[base + i / 16][15 - i % 16] = q[i];
  endtask
  initial begin
    int i, j, n, t, len;
    int cnt [8];
    logic [15:0] w, pat;
    cnt = '{1, 15, 16, 17, 47, 48, 49, 200};
    void'($urandom(32'h553d));
    {resetn, start, scan_end, slow, op, acc_in, stack1_in, stack2_in, stack3_in, operand} = '0;
    for (i = 0; i < 256; i++) put_word(i, 16'($urandom()));
    repeat (12) @(posedge clk);
    #1 resetn = 1'b1;
    for (i = 0; i < 16; i++) begin
      n = (i < 8) ? cnt[i] : $urandom_range(47, 1);
      slow = i[0];
      model_shift(i[1], 16'h0010, 3, n);
      run_op(i[1] ? 3'h0 : 3'h1, 16'h0010, 16'h0003, 16'h0, 16'h0, octal_code(n), 1'b0);
      check_mem();
      check_flags();
    end
    model_shift(1'b1, 16'h0010, 1, 17);
    run_op(3'h0, 16'h0010, 16'h0001, 16'h0, 16'h0, 16'h0021, 1'b0);
    check_flags();
    for (i = 0; i < 3; i++) begin
      pat = 16'($urandom());
      len = $urandom_range(8, 1);
      for (j = 0; j < len; j++) begin
        w = exp_mem[8'h40 + j];
        exp_mem[8'h60 + j] = (i == 0) ? (w & pat) : (i == 1) ? (w | pat) : (w ^ pat);
      end
      run_op(3'(2 + i), pat, 16'h0040, 16'(len), 16'h0, 16'h0060, i == 1);
      check_mem();
      check_flags();
    end
    @(posedge clk);
    #1 scan_end = 1'b1;
    @(posedge clk);
    #1 scan_end = 1'b0;
    {ovf_e, lost_e, lost_known} = 3'b001;
    @(posedge clk);
    #1 check_flags();
    for (i = 0; i < 16; i++) put_word(8'h80 + i, 16'h1000 + 16'(i));
    for (i = 0; i < 5; i++) begin
      t = i % 4;
      w = (i == 4) ? 16'hbeef : 16'h1000 + 16'(4 * t);
      put_word(8'hc0, w);
      put_word(8'hc1, w + 16'h0001);
      ovf_e = i == 4;
      run_op(table_ops_pkg::block_search, 16'h0080, 16'h008f, 16'h0004, (i == 1) ? 16'h3 : 16'h4, 16'h00c0, 1'b0);
      if (i < 4) `CHK("found block start", 16'h0080 + 16'(4 * t), got_acc)
      check_flags();
    end
    for (i = 0; i < 2; i++) begin
      len = i ? 8 : 1;
      slow = i[0];
      for (j = 0; j < len; j++) begin
        w = exp_mem[8'h20 + j];
        exp_mem[8'h20 + j] = exp_mem[8'h30 + j];
        exp_mem[8'h30 + j] = w;
      end
      run_op(table_ops_pkg::table_swap, 16'h0020, 16'(len), 16'h0, 16'h0, 16'h0030, 1'b0);
      check_mem();
    end
    results();
  end
endmodule
